// >>> logic/dtsm_pkg.sv
// Constants, register map, types and state record of the diagnostic timer and saturation monitor
// Behaviour
// - Two operating-hours counters, never clearable by command
// - Hours saved on supply loss, resumed after restart
// - First period elapsed raises calibration/service request
// - Further difference elapsed raises alarm and fault current
// - Reset before limit zeroes timer, monitoring stays
// - Acknowledge before limit is ignored
// - Acknowledge after limit clears message, blocks re-raise
// - Reset after limit clears message, restarts from zero
// - Configuration bit disables calibration/service monitoring entirely
// - Three min/max pairs: pressure, two temperatures
// - Min/max clearable by command, kept non-volatile
// - Min/max track simulated values when simulated
// - Saturation persisting full response time triggers interrupt
// - Saturation ending early cancels pending count
// - Interrupt lasts stop time to within one tick, then withdrawn
// - Fault current held until stop time elapsed
// - Fault direction from one of four settings
// - Current proportional to pressure between saturation limits
// - Restart disables every simulation
// - Fixed simulation on all three paths simultaneously
// - Pressure simulation replaces measured pressure for current
// - Temperature simulation never affects current or pressure
// - Warning reports only; interrupt also forces fault
package dtsm_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 25;              // Bus clock period
  localparam int unsigned TICK_PERIOD_MS  = 1000;            // Time-base period, one second
  localparam int unsigned TICK_CYCLES_DEF = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned HOUR_TICKS      = 3600;            // Ticks per operating hour

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CMD       = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_HOURS_EL  = 8'h0c;
  localparam logic [7:0] OFS_HOURS_SN  = 8'h10;
  localparam logic [7:0] OFS_CAL_LIM   = 8'h14;
  localparam logic [7:0] OFS_CAL_DIF   = 8'h18;
  localparam logic [7:0] OFS_SVC_LIM   = 8'h1c;
  localparam logic [7:0] OFS_SVC_DIF   = 8'h20;
  localparam logic [7:0] OFS_CAL_ELAP  = 8'h24;
  localparam logic [7:0] OFS_SVC_ELAP  = 8'h28;
  localparam logic [7:0] OFS_SAT_LO    = 8'h2c;
  localparam logic [7:0] OFS_SAT_HI    = 8'h30;
  localparam logic [7:0] OFS_SAT_RESP  = 8'h34;
  localparam logic [7:0] OFS_SAT_STOP  = 8'h38;
  localparam logic [7:0] OFS_SIM_BASE  = 8'h3c;             // Three words: pressure, sensor, electronics
  localparam logic [7:0] OFS_MM_BASE   = 8'h48;             // Three words: {max, min}
  localparam logic [7:0] OFS_LOOP      = 8'h54;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int CTL_COMMISSION = 0;                         // Write one to start hours counting
  localparam int CTL_TMR_EN     = 1;                         // Calibration/service monitoring on
  localparam int CTL_FAULT_HI   = 2;                         // General fault direction, 1 = upper
  localparam int CTL_DIR_LSB    = 3;                         // Two-bit saturation direction select
  localparam int CTL_SAT_INT    = 5;                         // Saturation raises interrupt too
  localparam int CTL_SAT_EN     = 6;                         // Saturation monitor on
  localparam int CTL_SIM_LSB    = 8;                         // Three simulation enables

  // Command register fields, write one to act
  localparam int CMD_TMR_RST0 = 0;                           // Timer k reset at bit 2k
  localparam int CMD_TMR_ACK0 = 1;                           // Timer k acknowledge at bit 2k+1
  localparam int CMD_MM_CLR0  = 4;                           // Min/max clear, three bits

  // Loop current codes while in fault
  localparam logic [15:0] FAULT_LO_CODE = 16'h8000;
  localparam logic [15:0] FAULT_HI_CODE = 16'h7fff;

  // Reset values of limits
  localparam logic [15:0] SAT_LO_RST = 16'h8000;
  localparam logic [15:0] SAT_HI_RST = 16'h7fff;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    DTSM_DIR_ACTIVE  = 2'h0,                                 // General fault direction
    DTSM_DIR_INVERSE = 2'h1,                                 // Its inverse
    DTSM_DIR_SAT     = 2'h2,                                 // Same side as saturation
    DTSM_DIR_INVSAT  = 2'h3                                  // Opposite side
  } dtsm_dir_t;

  typedef enum logic [2:0] {
    DTSM_SAT_IDLE = 3'h1,
    DTSM_SAT_RESP = 3'h2,
    DTSM_SAT_STOP = 3'h4
  } dtsm_sat_t;

  // Non-volatile image exchanged with storage
  typedef struct packed {
    logic              commissioned;
    logic [1:0][31:0]  hours;                                // 0 electronics, 1 sensor
    logic [2:0][15:0]  mm_min;
    logic [2:0][15:0]  mm_max;
  } dtsm_nv_t;

  // Whole state of the block
  typedef struct packed {
    logic              restored;                             // Non-volatile image loaded
    dtsm_nv_t          nv;                                   // Hours and peaks
    logic [31:0]       tick_cnt;                             // Time-base divider
    logic [11:0]       hour_pre;                             // Ticks within the current hour
    logic [10:0]       ctrl;
    logic [1:0][31:0]  tmr_lim;
    logic [1:0][31:0]  tmr_dif;
    logic [1:0][31:0]  tmr_elap;
    logic [1:0]        tmr_req;
    logic [1:0]        tmr_alarm;
    logic [1:0]        tmr_lock;                             // Limit reached and acknowledged
    logic [15:0]       sat_lo;
    logic [15:0]       sat_hi;
    logic [31:0]       sat_resp;
    logic [31:0]       sat_stop;
    dtsm_sat_t         sat_st;
    logic [31:0]       sat_cnt;
    logic              sat_dir_hi;                           // Saturation side at trigger
    logic [2:0][15:0]  sim_val;
    logic [15:0]       loop_code;
    logic              fault;
    logic              fault_hi;
    logic              nv_save;
    logic [31:0]       prdata;
    logic              pslverr;
  } dtsm_state_t;

endpackage : dtsm_pkg

// >>> logic/dtsm_top.sv
// Diagnostic timers, min/max trackers, saturation monitor and simulation behind an APB slave
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dtsm_top
  import dtsm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,      // Clock cycles per time-base tick
  parameter int unsigned TICKS_HOUR  = HOUR_TICKS            // Ticks per counted hour
) (
  // Clock and reset
  input  wire  logic              pclk,
  input  wire  logic              presetn,
  // APB slave
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [7:0]        paddr,
  input  wire  logic [31:0]       pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Measured values, signed
  input  wire  logic [15:0]       meas_pressure,
  input  wire  logic [15:0]       meas_sensor_temp,
  input  wire  logic [15:0]       meas_elec_temp,
  // Non-volatile storage
  input  wire  logic              supply_fail,
  input  wire  dtsm_nv_t          nv_image_in,
  output dtsm_nv_t                nv_image_out,
  output logic                    nv_save,
  // Analog output and diagnostics
  output logic [15:0]             loop_code,
  output logic                    fault_current,
  output logic                    fault_upper,
  output logic                    diag_warning
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (TICK_CYCLES < 1 || TICKS_HOUR < 1 || TICKS_HOUR > 4095) begin : g_bad_param
    $error("dtsm_top: tick or hour count out of range");
  end

  // ************************************************************
  // State and helpers
  // ************************************************************
  dtsm_state_t st;                                           // Registered state
  dtsm_state_t next_st;                                      // Next state

  // Saturating increment, never wraps
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == 32'hffffffff) ? v : v + 32'h00000001;
  endfunction : sat_inc

  // Saturating add of two limits for the alarm threshold
  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[32] ? 32'hffffffff : s[31:0];
  endfunction : sat_add

  // ************************************************************
  // Combinational next state
  // ************************************************************
  logic              tick;                                   // One-cycle time-base pulse
  logic              bus_wr;                                 // Write takes effect this edge
  logic              bus_setup;                              // Setup phase, read data prepared
  logic [31:0]       cmd;                                    // Command bits of this write
  logic [2:0][15:0]  active;                                 // Value seen by trackers
  logic [2:0][15:0]  meas;                                   // Measured values by path
  logic [15:0]       p_act;                                  // Pressure driving the current
  logic              sat_hi_now;                             // At or above upper limit
  logic              sat_lo_now;                             // At or below lower limit
  logic              sat_now;                                // Either limit
  logic              tmr_en;                                 // Timer monitoring enabled
  logic              tmr_fault;                              // Some timer alarm active
  logic              sat_fault;                              // Saturation interrupt active
  logic              sat_up;                                 // Chosen saturation fault side
  logic [31:0]       rd;                                     // Read data mux
  logic              rd_ok;                                  // Address is mapped

  always_comb begin
    next_st = st;
    meas    = {meas_elec_temp, meas_sensor_temp, meas_pressure};
    tick    = (st.tick_cnt == TICK_CYCLES - 1);
    bus_wr  = psel & penable & pwrite;
    bus_setup = psel & ~penable;
    cmd     = (bus_wr && paddr == OFS_CMD) ? pwdata : 32'h00000000;
    tmr_en  = st.ctrl[CTL_TMR_EN];

    // Time base divider
    next_st.tick_cnt = tick ? 32'h00000000 : st.tick_cnt + 32'h00000001;
    next_st.nv_save  = 1'b0;

    // Load the saved image once, first cycle after reset release
    if (!st.restored) begin
      next_st.restored = 1'b1;
      next_st.nv       = nv_image_in;
    end

    // Operating hours, counted once commissioned, no clear path
    if (st.restored && st.nv.commissioned && tick) begin
      if (st.hour_pre == 12'(TICKS_HOUR - 1)) begin
        next_st.hour_pre = 12'h000;
        for (int k = 0; k < 2; k++) begin
          next_st.nv.hours[k] = sat_inc(st.nv.hours[k]);
        end
      end else begin
        next_st.hour_pre = st.hour_pre + 12'h001;
      end
    end

    // Supply loss captures image for storage
    next_st.nv_save = supply_fail & st.restored;

    // Calibration (0) and service (1) timers
    for (int k = 0; k < 2; k++) begin
      if (!tmr_en) begin
        // Disabled: nothing raised, nothing pending
        next_st.tmr_req[k]   = 1'b0;
        next_st.tmr_alarm[k] = 1'b0;
      end else begin
        if (tick) begin
          next_st.tmr_elap[k] = sat_inc(st.tmr_elap[k]);
        end
        // Stages raised only while not acknowledged past the limit
        if (!st.tmr_lock[k] && st.tmr_elap[k] >= st.tmr_lim[k]) begin
          next_st.tmr_req[k] = 1'b1;
        end
        if (!st.tmr_lock[k] && st.tmr_elap[k] >= sat_add(st.tmr_lim[k], st.tmr_dif[k])) begin
          next_st.tmr_alarm[k] = 1'b1;
        end
        // Acknowledge: only once the first limit is reached
        if (cmd[CMD_TMR_ACK0 + 2 * k] && st.tmr_elap[k] >= st.tmr_lim[k]) begin
          next_st.tmr_req[k]   = 1'b0;
          next_st.tmr_alarm[k] = 1'b0;
          next_st.tmr_lock[k]  = 1'b1;
        end
      end
      // Reset: clear message and lock, restart from zero
      if (cmd[CMD_TMR_RST0 + 2 * k]) begin
        next_st.tmr_elap[k]  = 32'h00000000;
        next_st.tmr_req[k]   = 1'b0;
        next_st.tmr_alarm[k] = 1'b0;
        next_st.tmr_lock[k]  = 1'b0;
      end
    end
    tmr_fault = tmr_en & (|st.tmr_alarm);

    // Simulation selects the active value per path
    for (int k = 0; k < 3; k++) begin
      active[k] = st.ctrl[CTL_SIM_LSB + k] ? st.sim_val[k] : meas[k];
    end
    p_act = active[0];

    // Peak trackers follow the active value
    if (st.restored) begin
      for (int k = 0; k < 3; k++) begin
        if (cmd[CMD_MM_CLR0 + k]) begin
          next_st.nv.mm_min[k] = active[k];
          next_st.nv.mm_max[k] = active[k];
        end else begin
          if ($signed(active[k]) < $signed(st.nv.mm_min[k])) begin
            next_st.nv.mm_min[k] = active[k];
          end
          if ($signed(active[k]) > $signed(st.nv.mm_max[k])) begin
            next_st.nv.mm_max[k] = active[k];
          end
        end
      end
    end

    // Saturation detection on the pressure driving the output
    sat_hi_now = $signed(p_act) >= $signed(st.sat_hi);
    sat_lo_now = $signed(p_act) <= $signed(st.sat_lo);
    sat_now    = sat_hi_now | sat_lo_now;

    // Saturation monitor sequence
    case (st.sat_st)
      DTSM_SAT_IDLE: begin
        if (st.ctrl[CTL_SAT_EN] && sat_now) begin
          next_st.sat_st     = DTSM_SAT_RESP;
          next_st.sat_cnt    = 32'h00000000;
          next_st.sat_dir_hi = sat_hi_now;
        end
      end
      DTSM_SAT_RESP: begin
        if (!sat_now || !st.ctrl[CTL_SAT_EN]) begin
          next_st.sat_st = DTSM_SAT_IDLE;
        end else if (st.sat_cnt >= st.sat_resp) begin
          next_st.sat_st     = DTSM_SAT_STOP;
          next_st.sat_cnt    = 32'h00000000;
          next_st.sat_dir_hi = sat_hi_now;
        end else if (tick) begin
          next_st.sat_cnt = sat_inc(st.sat_cnt);
        end
      end
      DTSM_SAT_STOP: begin
        // Held regardless of the current returning inside limits
        if (st.sat_cnt >= st.sat_stop) begin
          next_st.sat_st = DTSM_SAT_IDLE;
        end else if (tick) begin
          next_st.sat_cnt = sat_inc(st.sat_cnt);
        end
      end
      default: begin
        next_st.sat_st = DTSM_SAT_IDLE;
      end
    endcase

    // Interrupt only when configured; otherwise a warning
    sat_fault = (st.sat_st == DTSM_SAT_STOP) & st.ctrl[CTL_SAT_INT];

    // Fault direction for saturation
    case (dtsm_dir_t'(st.ctrl[CTL_DIR_LSB +: 2]))
      DTSM_DIR_ACTIVE:  sat_up = st.ctrl[CTL_FAULT_HI];
      DTSM_DIR_INVERSE: sat_up = ~st.ctrl[CTL_FAULT_HI];
      DTSM_DIR_SAT:     sat_up = st.sat_dir_hi;
      DTSM_DIR_INVSAT:  sat_up = ~st.sat_dir_hi;
      default:          sat_up = st.ctrl[CTL_FAULT_HI];
    endcase

    // Loop current: fault, else clamped proportional pressure
    next_st.fault    = tmr_fault | sat_fault;
    next_st.fault_hi = sat_fault ? sat_up : st.ctrl[CTL_FAULT_HI];
    if (next_st.fault) begin
      next_st.loop_code = next_st.fault_hi ? FAULT_HI_CODE : FAULT_LO_CODE;
    end else if (sat_hi_now) begin
      next_st.loop_code = st.sat_hi;
    end else if (sat_lo_now) begin
      next_st.loop_code = st.sat_lo;
    end else begin
      next_st.loop_code = p_act;
    end

    // Register writes
    if (bus_wr) begin
      case (paddr)
        OFS_CTRL: begin
          // Commission bit can only be set, never cleared
          next_st.ctrl = pwdata[10:0] | {10'h000, st.ctrl[CTL_COMMISSION]};
          if (pwdata[CTL_COMMISSION]) begin
            next_st.nv.commissioned = 1'b1;
          end
        end
        OFS_CAL_LIM:  next_st.tmr_lim[0] = pwdata;
        OFS_CAL_DIF:  next_st.tmr_dif[0] = pwdata;
        OFS_SVC_LIM:  next_st.tmr_lim[1] = pwdata;
        OFS_SVC_DIF:  next_st.tmr_dif[1] = pwdata;
        OFS_SAT_LO:   next_st.sat_lo     = pwdata[15:0];
        OFS_SAT_HI:   next_st.sat_hi     = pwdata[15:0];
        OFS_SAT_RESP: next_st.sat_resp   = pwdata;
        OFS_SAT_STOP: next_st.sat_stop   = pwdata;
        OFS_SIM_BASE:        next_st.sim_val[0] = pwdata[15:0];
        OFS_SIM_BASE + 8'h4: next_st.sim_val[1] = pwdata[15:0];
        OFS_SIM_BASE + 8'h8: next_st.sim_val[2] = pwdata[15:0];
        default: begin
          // Read-only or command words: nothing stored
        end
      endcase
    end

    // Read mux, prepared in the setup phase
    rd_ok = 1'b1;
    case (paddr)
      OFS_CTRL:     rd = {21'h000000, st.ctrl};
      OFS_CMD:      rd = 32'h00000000;
      OFS_STATUS:   rd = {19'h00000, st.nv.commissioned, st.fault_hi, st.fault,
                          st.sat_st == DTSM_SAT_STOP, st.sat_st,
                          st.tmr_lock, st.tmr_alarm[1], st.tmr_req[1], st.tmr_alarm[0], st.tmr_req[0]};
      OFS_HOURS_EL: rd = st.nv.hours[0];
      OFS_HOURS_SN: rd = st.nv.hours[1];
      OFS_CAL_LIM:  rd = st.tmr_lim[0];
      OFS_CAL_DIF:  rd = st.tmr_dif[0];
      OFS_SVC_LIM:  rd = st.tmr_lim[1];
      OFS_SVC_DIF:  rd = st.tmr_dif[1];
      OFS_CAL_ELAP: rd = st.tmr_elap[0];
      OFS_SVC_ELAP: rd = st.tmr_elap[1];
      OFS_SAT_LO:   rd = {16'h0000, st.sat_lo};
      OFS_SAT_HI:   rd = {16'h0000, st.sat_hi};
      OFS_SAT_RESP: rd = st.sat_resp;
      OFS_SAT_STOP: rd = st.sat_stop;
      OFS_SIM_BASE:        rd = {16'h0000, st.sim_val[0]};
      OFS_SIM_BASE + 8'h4: rd = {16'h0000, st.sim_val[1]};
      OFS_SIM_BASE + 8'h8: rd = {16'h0000, st.sim_val[2]};
      OFS_MM_BASE:         rd = {st.nv.mm_max[0], st.nv.mm_min[0]};
      OFS_MM_BASE + 8'h4:  rd = {st.nv.mm_max[1], st.nv.mm_min[1]};
      OFS_MM_BASE + 8'h8:  rd = {st.nv.mm_max[2], st.nv.mm_min[2]};
      OFS_LOOP:     rd = {16'h0000, st.loop_code};
      default: begin
        rd    = 32'h00000000;                                // Unmapped reads zero
        rd_ok = 1'b0;
      end
    endcase
    if (bus_setup) begin
      next_st.prdata  = pwrite ? 32'h00000000 : rd;
      next_st.pslverr = ~rd_ok;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Reset is the restart: simulation, timers and monitor come up off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.sat_st   <= DTSM_SAT_IDLE;
      st.sat_lo   <= SAT_LO_RST;
      st.sat_hi   <= SAT_HI_RST;
      st.fault_hi <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign pready        = 1'b1;                               // Zero wait states
  assign prdata        = st.prdata;
  assign pslverr       = psel & penable & st.pslverr;
  assign nv_image_out  = st.nv;
  assign nv_save       = st.nv_save;
  assign loop_code     = st.loop_code;
  assign fault_current = st.fault;
  assign fault_upper   = st.fault_hi;
  // Warning covers timer messages and any saturation held past response time
  assign diag_warning  = (|st.tmr_req) | (|st.tmr_alarm) | (st.sat_st == DTSM_SAT_STOP);

endmodule : dtsm_top
`default_nettype wire

// >>> tb/dtsm_nv_model.sv
// Non-volatile storage model that keeps the block's image across restarts
`timescale 1ns/1ps
`default_nettype none
module dtsm_nv_model
  import dtsm_pkg::*;
(
  // Clock and save strobe
  input  wire logic     pclk,
  input  wire logic     nv_save,
  // Image to and from the block
  input  wire dtsm_nv_t nv_image_out,
  output var  dtsm_nv_t nv_image_in
);
  // Commissioned image with a few hours already logged
  initial nv_image_in = {1'h1, 32'h9, 32'h5, 96'h0};
  // Capture every save so a restart resumes from it
  always @(posedge pclk) if (nv_save) nv_image_in <= nv_image_out;
endmodule : dtsm_nv_model
`default_nettype wire

// >>> tb/dtsm_top_asserts.sv
// Port-level checks of the diagnostic timer and saturation block
`timescale 1ns/1ps
`default_nettype none
module dtsm_top_asserts
  import dtsm_pkg::*;
(
  // Watched ports
  input wire logic        pclk, presetn, psel, penable, pslverr, supply_fail, nv_save,
  input wire logic        fault_current, fault_upper, diag_warning,
  input wire logic [15:0] loop_code,
  input wire logic [7:0]  paddr,
  input wire dtsm_nv_t    nv_image_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Hours never drop, so no command clears them and they never wrap
  a_hours_grow: assert property (nv_image_out.hours[0] >= $past(nv_image_out.hours[0]) &&
    nv_image_out.hours[1] >= $past(nv_image_out.hours[1])) else $error("hours counter dropped");
  a_commission_kept: assert property (!$fell(nv_image_out.commissioned))
    else $error("commissioning lost");
  a_save_cause: assert property (nv_save |-> $past(supply_fail))
    else $error("save without supply loss");
  a_save_on_fail: assert property (supply_fail && $past(supply_fail) |=> nv_save)
    else $error("supply loss not saved");
  a_fault_code: assert property (fault_current && $past(fault_current) |->
    loop_code == (fault_upper ? FAULT_HI_CODE : FAULT_LO_CODE)) else $error("fault code wrong");
  a_fault_warned: assert property ($rose(fault_current) |-> diag_warning || $past(diag_warning))
    else $error("fault without diagnostic");
  a_peak_order: assert property ($signed(nv_image_out.mm_min[0]) <= $signed(nv_image_out.mm_max[0]) &&
    $signed(nv_image_out.mm_min[1]) <= $signed(nv_image_out.mm_max[1])) else $error("peaks crossed");
  a_err_access: assert property (pslverr == (psel && penable && (paddr > OFS_LOOP || paddr[1:0] != 2'h0)))
    else $error("error flag not matching address");
endmodule : dtsm_top_asserts
bind dtsm_top dtsm_top_asserts chk (.*);
`default_nettype wire

// >>> tb/dtsm_top_tb_top.sv
// Register-level tests of the diagnostic timer and saturation block
`timescale 1ns/1ps
`default_nettype none
module dtsm_top_tb_top;
  import dtsm_pkg::*;
  // Bus, measurement and storage signals; temperatures stay fixed
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, supply_fail = 1'h0;
  logic pready, pslverr, nv_save, fault_current, fault_upper, diag_warning, er;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [15:0] meas_pressure = 16'h0, meas_sensor_temp = 16'h10, meas_elec_temp = 16'h11, loop_code;
  dtsm_nv_t nv_image_in, nv_image_out;
  int bad_count = 0, n_tests = 0;
  always #12.5 pclk = ~pclk;
  // Short tick so timers run in a few cycles
  dtsm_top #(.TICK_CYCLES(4), .TICKS_HOUR(2)) uut (.*);
  dtsm_nv_model nvm (.*);
  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // One APB transfer, request held until pready is seen
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rv = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : xf
  // Bounded polling read, then compare; stale data dropped first so one fresh read always happens
  task automatic poll(input string n, input logic [7:0] a, input logic [31:0] m, v);
    rv = 32'hx;
    for (int i = 0; i < 300 && (rv & m) !== v; i++) xf(1'h0, a, 32'h0);
    chk(n, v, rv & m);
  endtask : poll
  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  initial begin
    #500us;
    bad_count++;
    stop_test();
  end
  initial begin
    rv = 32'hx;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    xf(1'h0, 8'hfc, 32'h0);
    chk("unmapped", 32'h1, {rv[30:0], er});
    xf(1'h1, OFS_CMD, 32'h7f);
    poll("hours_el", OFS_HOURS_EL, 32'hffffffff, 32'h7);
    // Two-stage timer: early ack ignored, request, alarm, ack, reset
    xf(1'h1, OFS_CAL_LIM, 32'h4);
    xf(1'h1, OFS_CAL_DIF, 32'h4);
    xf(1'h1, OFS_SVC_LIM, 32'hffff); // Service timer kept far off, else it alarms at once
    xf(1'h1, OFS_CTRL, 32'h7);
    xf(1'h1, OFS_CMD, 32'h2);
    poll("cal_req", OFS_STATUS, 32'h3, 32'h1);
    chk("cal_warn", 32'h1, {fault_current, diag_warning});
    poll("cal_alarm", OFS_STATUS, 32'h2, 32'h2);
    chk("timer_fault", 32'h37fff, {fault_current, fault_upper, loop_code});
    xf(1'h1, OFS_CMD, 32'h2);
    poll("cal_ack", OFS_STATUS, 32'h413, 32'h10);
    xf(1'h1, OFS_CMD, 32'h1);
    xf(1'h0, OFS_CAL_ELAP, 32'h0);
    chk("cal_restart", 32'h1, {31'h0, rv < 32'h2});
    poll("cal_rearm", OFS_STATUS, 32'h1, 32'h1);
    xf(1'h1, OFS_CTRL, 32'h1);
    poll("tmr_off", OFS_STATUS, 32'h403, 32'h0);
    // Saturation: short pulse cancelled, then every direction setting
    xf(1'h1, OFS_SAT_HI, 32'h64);
    xf(1'h1, OFS_SAT_RESP, 32'h2);
    xf(1'h1, OFS_SAT_STOP, 32'h4);
    xf(1'h1, OFS_CTRL, 32'h61);
    meas_pressure <= 16'hc8;
    @(posedge pclk);
    meas_pressure <= 16'h0;
    repeat (5) xf(1'h0, OFS_STATUS, 32'h0);
    chk("sat_cancel", 32'h1, {rv[10], rv[8:6]});
    for (int d = 0; d < 4; d++) begin
      xf(1'h1, OFS_CTRL, 32'h61 | (d << 3));
      meas_pressure <= 16'hc8;
      poll("sat_fault", OFS_STATUS, 32'h400, 32'h400);
      chk("fault_upper", 32'(4'h6 >> d) & 32'h1, {31'h0, fault_upper});
      meas_pressure <= 16'h0;
      xf(1'h0, OFS_STATUS, 32'h0);
      chk("fault_held", 32'h400, rv & 32'h400);
      poll("fault_end", OFS_STATUS, 32'h400, 32'h0);
    end
    // Fixed simulation on pressure and sensor temperature together
    meas_pressure <= 16'h20;
    xf(1'h1, OFS_SIM_BASE, 32'h50);
    chk("loop_meas", 32'h20, {16'h0, loop_code});
    xf(1'h1, OFS_SIM_BASE + 8'h4, 32'h7000);
    xf(1'h1, OFS_CTRL, 32'h301);
    @(posedge pclk); // Loop code lags the control write by one edge
    chk("loop_sim", 32'h50, {16'h0, loop_code});
    xf(1'h1, OFS_CMD, 32'h10);
    xf(1'h0, OFS_MM_BASE, 32'h0);
    chk("mm_clear", 32'h00500050, rv);
    xf(1'h0, OFS_MM_BASE + 8'h4, 32'h0);
    chk("mm_sim_temp", 32'h70000010, rv);
    // Supply loss then restart: hours resume, simulation is off
    supply_fail <= 1'h1;
    repeat (2) @(posedge pclk);
    supply_fail <= 1'h0;
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    chk("loop_restart", 32'h20, {16'h0, loop_code});
    xf(1'h0, OFS_HOURS_EL, 32'h0);
    chk("hours_kept", 32'h1, {31'h0, rv >= 32'h7});
    stop_test();
  end
endmodule : dtsm_top_tb_top
`default_nettype wire
